// File: core/uefr_pkg.sv
// package for the enhanced uart feature register bank
package uefr_pkg;
  // register byte offsets on the bus
  localparam logic [7:0] OFF_MODEM_CONTROL = 8'h00;
  localparam logic [7:0] OFF_MODEM_STATUS  = 8'h04;
  localparam logic [7:0] OFF_SCRATCH       = 8'h08;
  localparam logic [7:0] OFF_DIV_LOW       = 8'h0C;
  localparam logic [7:0] OFF_DIV_HIGH      = 8'h10;
  localparam logic [7:0] OFF_DIV_FRAC      = 8'h14;
  localparam logic [7:0] OFF_DEV_ID        = 8'h18;
  localparam logic [7:0] OFF_DEV_REV       = 8'h1C;
  localparam logic [7:0] OFF_TRIGGER       = 8'h20;
  localparam logic [7:0] OFF_FIFO_COUNT    = 8'h24;
  localparam logic [7:0] OFF_FEATURE       = 8'h28;
  localparam logic [7:0] OFF_LINE_CONTROL  = 8'h2C;
  localparam logic [7:0] OFF_ENH_FEATURE   = 8'h30;
  localparam logic [7:0] OFF_FIFO_LEVELS   = 8'h34;
  localparam logic [7:0] OFF_CONFIG_STATUS = 8'h38;
  localparam logic [7:0] OFF_TRIG_READBACK = 8'h3C;
  // reset values
  localparam logic [7:0] RST_SCRATCH       = 8'hFF;
  localparam logic [7:0] RST_ENH_MODE      = 8'h80;
  localparam logic [7:0] RST_ZERO          = 8'h00;
  localparam logic [7:0] RST_DIV_LOW       = 8'h01;
  // identity codes, values arbitrary
  localparam logic [7:0] ID_CODE           = 8'h5C;
  localparam logic [7:0] REV_CODE          = 8'h03;
  // key values
  localparam logic [7:0] LCR_ENHANCED_KEY  = 8'hBF;
  // field positions
  localparam int MCR_RI_BIT        = 2;
  localparam int MCR_CD_BIT        = 3;
  localparam int MCR_LOOP_BIT      = 4;
  localparam int EFR_ENABLE_BIT    = 4;
  localparam int FEATURE_CONTROL_IR_INV_BIT   = 2;
  localparam int FEATURE_CONTROL_HALF_BIT     = 3;
  localparam int FEATURE_CONTROL_TBL_LO       = 4;
  localparam int FEATURE_CONTROL_TBL_HI       = 5;
  localparam int FEATURE_CONTROL_SWAP_BIT     = 6;
  localparam int FEATURE_CONTROL_TRG_TX_BIT   = 7;
  localparam int EMS_CNT_LO        = 0;
  localparam int EMS_CNT_HI        = 1;
  localparam int EMS_HYS_LO        = 4;
  localparam int EMS_HYS_HI        = 5;
  localparam int EMS_LSR_IMM_BIT   = 6;
  localparam int EMS_16X_BIT       = 7;
  // trigger table d code
  localparam logic [1:0] TABLE_D   = 2'h3;
  // hysteresis table indexed by {ems[5:4], feature_control[1:0]}
  localparam logic [5:0] HYS_TABLE [16] = '{
    6'h00, 6'h04, 6'h06, 6'h08, 6'h08, 6'h10, 6'h18, 6'h20,
    6'h28, 6'h2C, 6'h30, 6'h34, 6'h0C, 6'h14, 6'h1C, 6'h24};
  // alternate counter read phase
  typedef enum logic [0:0] {
    UEFR_ALT_RX = 1'b0,
    UEFR_ALT_TX = 1'b1
  } uefr_alt_t;
endpackage : uefr_pkg

// File: core/uefr_regs.sv
// enhanced uart feature register bank with ahb-lite slave
// Contract
// - loopback ring indicator status equals control bit2
// - loopback carrier detect equals control bit3
// - scratch register resets to FF
// - swap bit redirects scratch writes to mode
// - mode bits pick rx, tx or alternate
// - alternate reads start rx then alternate
// - hysteresis from mode and feature bits table
// - mode bit6 selects immediate line status interrupt
// - mode bit7 selects 16x sampling, default
// - swap bit makes scratch reads show level
// - divisor is high,low plus fraction/16
// - fraction writable only with enhance bit set
// - identification code readable with zero divisor
// - revision code readable with zero divisor
// - trigger register programs table d levels
// - fifo count needs line control BF
// - feature bit2 selects infrared rx polarity
// - feature bit3 overrides duplex pin
// - half duplex delays transmit interrupt
// - feature bits5:4 select trigger table
// - enhance bit gates enhanced bit changes
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module uefr_regs (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // fifo state from the serial engine
  input  wire logic [7:0]  rx_fifo_level,
  input  wire logic [7:0]  tx_fifo_level,
  input  wire logic        thr_empty_evt,
  input  wire logic        tsr_empty_evt,
  input  wire logic        duplex_pin,
  input  wire logic        rts_internal,
  // configuration out to the serial engine
  output logic [19:0]      baud_divisor,
  output logic             sample_16x,
  output logic             lsr_irq_immediate,
  output logic [5:0]       hysteresis,
  output logic [1:0]       trigger_table,
  output logic             ir_rx_invert,
  output logic             half_duplex,
  output logic             driver_enable,
  output logic             tx_irq_pulse,
  output logic [7:0]       rx_trigger,
  output logic [7:0]       tx_trigger
);

  ////////////////////////////////////////////////////////////////////////
  // bus address phase capture
  logic        ph_valid_q, ph_valid_d;
  logic        ph_write_q, ph_write_d;
  logic [7:0]  ph_addr_q,  ph_addr_d;
  logic        take;

  assign take = hsel && hready && htrans[1];

  // latch the address phase
  always_comb begin
    ph_valid_d = take;
    ph_write_d = take ? hwrite : ph_write_q;
    ph_addr_d  = take ? haddr : ph_addr_q;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_valid_q <= 1'b0;
      ph_write_q <= 1'b0;
      ph_addr_q  <= 8'h00;
    end else begin
      ph_valid_q <= ph_valid_d;
      ph_write_q <= ph_write_d;
      ph_addr_q  <= ph_addr_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] mcr_q, mcr_d, lcr_q, lcr_d, efr_q, efr_d;
  logic [7:0] spr_q, spr_d, ems_q, ems_d, feature_control_q, feature_control_d;
  logic [7:0] dll_q, dll_d, dlm_q, dlm_d, dld_q, dld_d;
  logic [7:0] rtrg_q, rtrg_d, ttrg_q, ttrg_d;
  uefr_pkg::uefr_alt_t alt_q, alt_d;
  logic       wr, rd, enh, swap, div_zero;

  assign wr       = ph_valid_q && ph_write_q;
  assign rd       = ph_valid_q && !ph_write_q;
  assign enh      = efr_q[uefr_pkg::EFR_ENABLE_BIT];
  assign swap     = feature_control_q[uefr_pkg::FEATURE_CONTROL_SWAP_BIT];
  assign div_zero = (dll_q == uefr_pkg::RST_ZERO) && (dlm_q == uefr_pkg::RST_ZERO);

  // write decode and alternate read phase
  always_comb begin
    mcr_d  = mcr_q;
    lcr_d  = lcr_q;
    efr_d  = efr_q;
    spr_d  = spr_q;
    ems_d  = ems_q;
    feature_control_d = feature_control_q;
    dll_d  = dll_q;
    dlm_d  = dlm_q;
    dld_d  = dld_q;
    rtrg_d = rtrg_q;
    ttrg_d = ttrg_q;
    alt_d  = alt_q;
    if (wr) begin
      case (ph_addr_q)
        uefr_pkg::OFF_MODEM_CONTROL: begin
          mcr_d[4:0] = hwdata[4:0];
          if (enh) mcr_d[7:5] = hwdata[7:5];
        end
        uefr_pkg::OFF_LINE_CONTROL:  lcr_d = hwdata[7:0];
        uefr_pkg::OFF_ENH_FEATURE:   efr_d = hwdata[7:0];
        uefr_pkg::OFF_SCRATCH: begin
          if (swap) begin
            ems_d = hwdata[7:0];
            alt_d = uefr_pkg::UEFR_ALT_RX;
          end else begin
            spr_d = hwdata[7:0];
          end
        end
        uefr_pkg::OFF_FEATURE:       feature_control_d = hwdata[7:0];
        uefr_pkg::OFF_DIV_LOW:       dll_d = hwdata[7:0];
        uefr_pkg::OFF_DIV_HIGH:      dlm_d = hwdata[7:0];
        uefr_pkg::OFF_DIV_FRAC: begin
          if (enh) dld_d = hwdata[7:0];
        end
        uefr_pkg::OFF_TRIGGER: begin
          if (feature_control_q[uefr_pkg::FEATURE_CONTROL_TRG_TX_BIT]) ttrg_d = hwdata[7:0];
          else rtrg_d = hwdata[7:0];
        end
        default: ;
      endcase
    end else if (take && !hwrite && swap && haddr == uefr_pkg::OFF_SCRATCH
                 && ems_q[uefr_pkg::EMS_CNT_HI:uefr_pkg::EMS_CNT_LO] == 2'h3) begin
      // advance with the address phase, so back to back reads alternate too
      alt_d = (alt_q == uefr_pkg::UEFR_ALT_RX) ? uefr_pkg::UEFR_ALT_TX
                                                : uefr_pkg::UEFR_ALT_RX;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mcr_q  <= uefr_pkg::RST_ZERO;
      lcr_q  <= uefr_pkg::RST_ZERO;
      efr_q  <= uefr_pkg::RST_ZERO;
      spr_q  <= uefr_pkg::RST_SCRATCH;
      ems_q  <= uefr_pkg::RST_ENH_MODE;
      feature_control_q <= uefr_pkg::RST_ZERO;
      dll_q  <= uefr_pkg::RST_DIV_LOW;
      dlm_q  <= uefr_pkg::RST_ZERO;
      dld_q  <= uefr_pkg::RST_ZERO;
      rtrg_q <= uefr_pkg::RST_ZERO;
      ttrg_q <= uefr_pkg::RST_ZERO;
      alt_q  <= uefr_pkg::UEFR_ALT_RX;
    end else begin
      mcr_q  <= mcr_d;
      lcr_q  <= lcr_d;
      efr_q  <= efr_d;
      spr_q  <= spr_d;
      ems_q  <= ems_d;
      feature_control_q <= feature_control_d;
      dll_q  <= dll_d;
      dlm_q  <= dlm_d;
      dld_q  <= dld_d;
      rtrg_q <= rtrg_d;
      ttrg_q <= ttrg_d;
      alt_q  <= alt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data and derived outputs
  logic [7:0]  rdata8, modem_status, level_sel;
  logic [31:0] hrdata_d;
  logic        loop, tx_irq_d, drv_d, half_d;
  logic [19:0] div_d;

  assign loop = mcr_q[uefr_pkg::MCR_LOOP_BIT];

  // modem status in loopback mirrors control bits
  always_comb begin
    modem_status = 8'h00;
    if (loop) begin
      modem_status[4] = mcr_q[1];
      modem_status[5] = mcr_q[0];
      modem_status[6] = mcr_q[uefr_pkg::MCR_RI_BIT];
      modem_status[7] = mcr_q[uefr_pkg::MCR_CD_BIT];
    end
  end

  // level counter mode select
  always_comb begin
    if (!ems_q[uefr_pkg::EMS_CNT_LO]) level_sel = rx_fifo_level;
    else if (!ems_q[uefr_pkg::EMS_CNT_HI]) level_sel = tx_fifo_level;
    else level_sel = (alt_q == uefr_pkg::UEFR_ALT_RX) ? rx_fifo_level : tx_fifo_level;
  end

  // read mux, unmapped reads zero
  always_comb begin
    rdata8 = 8'h00;
    case (haddr)
      uefr_pkg::OFF_MODEM_CONTROL: rdata8 = mcr_q;
      uefr_pkg::OFF_MODEM_STATUS:  rdata8 = modem_status;
      uefr_pkg::OFF_SCRATCH:       rdata8 = swap ? level_sel : spr_q;
      uefr_pkg::OFF_DIV_LOW:       rdata8 = dll_q;
      uefr_pkg::OFF_DIV_HIGH:      rdata8 = dlm_q;
      uefr_pkg::OFF_DIV_FRAC:      rdata8 = enh ? dld_q : 8'h00;
      uefr_pkg::OFF_DEV_ID:        rdata8 = div_zero ? uefr_pkg::ID_CODE : 8'h00;
      uefr_pkg::OFF_DEV_REV:       rdata8 = div_zero ? uefr_pkg::REV_CODE : 8'h00;
      uefr_pkg::OFF_FIFO_COUNT: begin
        if (lcr_q == uefr_pkg::LCR_ENHANCED_KEY)
          rdata8 = feature_control_q[uefr_pkg::FEATURE_CONTROL_TRG_TX_BIT] ? tx_fifo_level : rx_fifo_level;
      end
      uefr_pkg::OFF_FEATURE:       rdata8 = feature_control_q;
      uefr_pkg::OFF_LINE_CONTROL:  rdata8 = lcr_q;
      uefr_pkg::OFF_ENH_FEATURE:   rdata8 = efr_q;
      default:                     rdata8 = 8'h00;
    endcase
    hrdata_d = {24'h000000, rdata8};
  end

  // divisor: integer part in 19:4, fraction in 3:0
  always_comb begin
    div_d = {dlm_q, dll_q, dld_q[3:0]};
    half_d = feature_control_q[uefr_pkg::FEATURE_CONTROL_HALF_BIT] | duplex_pin;
    drv_d = feature_control_q[uefr_pkg::FEATURE_CONTROL_HALF_BIT] ? rts_internal : 1'b1;
    tx_irq_d = half_d ? tsr_empty_evt : thr_empty_evt;
  end

  // registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata            <= 32'h00000000;
      baud_divisor      <= 20'h00010;
      sample_16x        <= 1'b1;
      lsr_irq_immediate <= 1'b0;
      hysteresis        <= 6'h00;
      trigger_table     <= 2'h0;
      ir_rx_invert      <= 1'b0;
      half_duplex       <= 1'b0;
      driver_enable     <= 1'b1;
      tx_irq_pulse      <= 1'b0;
      rx_trigger        <= 8'h00;
      tx_trigger        <= 8'h00;
    end else begin
      if (take && !hwrite) hrdata <= hrdata_d;
      baud_divisor      <= div_d;
      sample_16x        <= ems_q[uefr_pkg::EMS_16X_BIT];
      lsr_irq_immediate <= ems_q[uefr_pkg::EMS_LSR_IMM_BIT];
      hysteresis        <= uefr_pkg::HYS_TABLE[{ems_q[uefr_pkg::EMS_HYS_HI:uefr_pkg::EMS_HYS_LO],
                                                feature_control_q[1:0]}];
      trigger_table     <= feature_control_q[uefr_pkg::FEATURE_CONTROL_TBL_HI:uefr_pkg::FEATURE_CONTROL_TBL_LO];
      ir_rx_invert      <= feature_control_q[uefr_pkg::FEATURE_CONTROL_IR_INV_BIT];
      half_duplex       <= half_d;
      driver_enable     <= drv_d;
      tx_irq_pulse      <= tx_irq_d;
      rx_trigger        <= (feature_control_q[uefr_pkg::FEATURE_CONTROL_TBL_HI:uefr_pkg::FEATURE_CONTROL_TBL_LO]
                            == uefr_pkg::TABLE_D) ? rtrg_q : 8'h00;
      tx_trigger        <= (feature_control_q[uefr_pkg::FEATURE_CONTROL_TBL_HI:uefr_pkg::FEATURE_CONTROL_TBL_LO]
                            == uefr_pkg::TABLE_D) ? ttrg_q : 8'h00;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  sequence swap_wr_s;
    wr && swap && ph_addr_q == uefr_pkg::OFF_SCRATCH;
  endsequence

  loop_ri_a: assert property (@(posedge hclk) disable iff (!hresetn)
    loop |-> modem_status[6] == mcr_q[uefr_pkg::MCR_RI_BIT]) else $error("ring status mismatch");
  loop_cd_a: assert property (@(posedge hclk) disable iff (!hresetn)
    loop |-> modem_status[7] == mcr_q[uefr_pkg::MCR_CD_BIT]) else $error("carrier status mismatch");
  swap_ems_a: assert property (@(posedge hclk) disable iff (!hresetn)
    swap_wr_s |=> ems_q == $past(hwdata[7:0]) && $stable(spr_q))
    else $error("swap write missed mode");
  alt_restart_a: assert property (@(posedge hclk) disable iff (!hresetn)
    swap_wr_s |=> alt_q == uefr_pkg::UEFR_ALT_RX) else $error("alternate not restarted");
  frac_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (wr && ph_addr_q == uefr_pkg::OFF_DIV_FRAC && !enh) |=> $stable(dld_q))
    else $error("fraction changed while locked");
  div_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> baud_divisor == {$past(dlm_q), $past(dll_q), $past(dld_q[3:0])})
    else $error("divisor wrong");
  samp_out_a: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |=> sample_16x == $past(ems_q[uefr_pkg::EMS_16X_BIT]))
    else $error("sampling mode wrong");
  tx_irq_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (feature_control_q[uefr_pkg::FEATURE_CONTROL_HALF_BIT] && !tsr_empty_evt) |=> !tx_irq_pulse)
    else $error("early tx interrupt");
endmodule : uefr_regs

// File: bench/test_uefr_regs.sv
// self-checking bench for the enhanced uart feature register bank
`timescale 1ns/1ps
module test_uefr_regs;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_dp;
  logic [7:0]  haddr, rx_fifo_level, tx_fifo_level, rx_trigger, tx_trigger, lo;
  logic [1:0]  htrans, trigger_table;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata;
  logic        thr_empty_evt, tsr_empty_evt, duplex_pin, rts_internal, d0;
  logic [19:0] baud_divisor;
  logic        sample_16x, lsr_irq_immediate, ir_rx_invert, half_duplex;
  logic        driver_enable, tx_irq_pulse;
  logic [5:0]  hysteresis;
  logic [15:0] rnd;
  logic [7:0]  q_exp[$];
  logic [7:0]  q_msk[$];
  int          n_fail;
  int          total_checks;
  // expected hysteresis in characters, index {mode[5:4], feature[1:0]}
  logic [5:0]  hys_tab[16] = '{6'd0, 6'd4, 6'd6, 6'd8, 6'd8, 6'd16, 6'd24, 6'd32,
                               6'd40, 6'd44, 6'd48, 6'd52, 6'd12, 6'd20, 6'd28, 6'd36};

  uefr_regs uefr_regs_i (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp,
    .rx_fifo_level, .tx_fifo_level, .thr_empty_evt, .tsr_empty_evt,
    .duplex_pin, .rts_internal, .baud_divisor, .sample_16x, .lsr_irq_immediate,
    .hysteresis, .trigger_table, .ir_rx_invert, .half_duplex, .driver_enable,
    .tx_irq_pulse, .rx_trigger, .tx_trigger);

  ////////////////////////////////////////////////////////////////////////////
  // clock generation
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  // pseudo random source
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  task automatic err(input string s);
    n_fail++;
    $display("[ERR] %0t %s", $time, s);
  endtask : err

  task automatic summarize();
    if (n_fail == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  // compare one read word, low byte under mask, upper bits zero
  task automatic cmp(input logic [31:0] g, input logic [7:0] e, input logic [7:0] m);
    total_checks++;
    if ((g & {24'hFFFFFF, m}) !== {24'h0, e & m} || hresp !== 1'b0) err("read data mismatch");
  endtask : cmp

  // compare one configuration output
  task automatic chk(input logic [19:0] g, input logic [19:0] e);
    total_checks++;
    if (g !== e) err("output mismatch");
  endtask : chk

  ////////////////////////////////////////////////////////////////////////////
  // bounded wait for hready at a rising edge
  task automatic wait_rdy();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (k >= 20) begin
      err("bus timeout");
      summarize();
    end
  endtask : wait_rdy

  // single word transfer, read expectation queued with the address phase
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                      input logic [7:0] m);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    if (!w) q_exp.push_back(d);
    if (!w) q_msk.push_back(m);
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    wait_rdy();
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, d, 8'h00);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    xfer(a, 1'b0, e, m);
  endtask : rd

  // let a register change reach the outputs
  task automatic settle();
    repeat (2) @(posedge hclk);
    #1;
  endtask : settle

  // one event pulse, then look at the registered transmit interrupt
  task automatic pulse(input logic tsr, input logic e);
    tsr_empty_evt <= tsr;
    thr_empty_evt <= !tsr;
    @(posedge hclk);
    tsr_empty_evt <= 1'b0;
    thr_empty_evt <= 1'b0;
    #1;
    chk(tx_irq_pulse, e);
    @(posedge hclk);
  endtask : pulse

  ////////////////////////////////////////////////////////////////////////////
  // read monitor, takes the oldest expectation in each read data phase
  always @(posedge hclk) begin
    if (rd_dp) cmp(hrdata, q_exp.pop_front(), q_msk.pop_front());
    rd_dp <= hresetn && hsel && htrans[1] && !hwrite && hreadyout;
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {hresetn, hsel, hwrite, thr_empty_evt, tsr_empty_evt, duplex_pin} = 6'h00;
    {haddr, htrans, hwdata, rts_internal} = '0;
    hsize = 3'h2;
    rnd = 16'd20764;
    rx_fifo_level = 8'h00;
    tx_fifo_level = 8'h00;
    n_fail = 0;
    total_checks = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(uefr_pkg::OFF_SCRATCH, 8'hFF, 8'hFF);
    chk(sample_16x, 20'h1);
    chk(baud_divisor, 20'h00010);
    rnd = lfsr(rnd);
    lo = rnd[7:0];
    wr(uefr_pkg::OFF_SCRATCH, lo);
    rd(uefr_pkg::OFF_SCRATCH, lo, 8'hFF);
    // loopback ring indicator and carrier detect
    for (int i = 0; i < 4; i++) begin
      wr(uefr_pkg::OFF_MODEM_CONTROL, {3'b000, 1'b1, i[1:0], 2'b00});
      rd(uefr_pkg::OFF_MODEM_STATUS, {i[1:0], 6'h00}, 8'hC0);
    end
    // swapped scratch address, every level counter mode
    wr(uefr_pkg::OFF_FEATURE, 8'h40);
    for (int m = 0; m < 4; m++) begin
      rnd = lfsr(rnd);
      rx_fifo_level <= rnd[7:0];
      tx_fifo_level <= ~rnd[7:0];
      wr(uefr_pkg::OFF_SCRATCH, m[7:0]);
      for (int r = 0; r < 3; r++) begin
        rd(uefr_pkg::OFF_SCRATCH, (m == 1 || (m == 3 && r == 1)) ? ~rnd[7:0] : rnd[7:0],
           8'hFF);
      end
    end
    wr(uefr_pkg::OFF_SCRATCH, 8'h03);
    rd(uefr_pkg::OFF_SCRATCH, rnd[7:0], 8'hFF);
    settle();
    chk({sample_16x, lsr_irq_immediate}, 20'h0);
    wr(uefr_pkg::OFF_FEATURE, 8'h00);
    rd(uefr_pkg::OFF_SCRATCH, lo, 8'hFF);
    // hysteresis table, mode bits 7 and 6 set
    for (int i = 0; i < 16; i++) begin
      wr(uefr_pkg::OFF_FEATURE, {6'h10, i[1:0]});
      wr(uefr_pkg::OFF_SCRATCH, {2'b11, i[3:2], 4'h0});
      settle();
      chk(hysteresis, hys_tab[i]);
    end
    chk({sample_16x, lsr_irq_immediate}, 20'h3);
    // divisor, fraction gate, identity
    rnd = lfsr(rnd);
    lo = rnd[7:0] | 8'h01;
    wr(uefr_pkg::OFF_DIV_LOW, lo);
    wr(uefr_pkg::OFF_DIV_HIGH, rnd[15:8]);
    wr(uefr_pkg::OFF_DIV_FRAC, 8'h0B);
    rd(uefr_pkg::OFF_DIV_FRAC, 8'h00, 8'hFF);
    rd(uefr_pkg::OFF_DEV_ID, 8'h00, 8'hFF);
    wr(uefr_pkg::OFF_ENH_FEATURE, 8'h10);
    wr(uefr_pkg::OFF_DIV_FRAC, 8'h0B);
    rd(uefr_pkg::OFF_DIV_FRAC, 8'h0B, 8'hFF);
    wr(uefr_pkg::OFF_ENH_FEATURE, 8'h00);
    wr(uefr_pkg::OFF_DIV_FRAC, 8'h05);
    settle();
    chk(baud_divisor, {rnd[15:8], lo, 4'hB});
    wr(uefr_pkg::OFF_DIV_LOW, 8'h00);
    wr(uefr_pkg::OFF_DIV_HIGH, 8'h00);
    rd(uefr_pkg::OFF_DEV_ID, uefr_pkg::ID_CODE, 8'hFF);
    rd(uefr_pkg::OFF_DEV_REV, uefr_pkg::REV_CODE, 8'hFF);
    // trigger tables, programmable levels, fifo count
    for (int t = 0; t < 4; t++) begin
      wr(uefr_pkg::OFF_FEATURE, {2'b00, t[1:0], 4'h0});
      settle();
      chk(trigger_table, t[1:0]);
    end
    wr(uefr_pkg::OFF_FEATURE, 8'hB0);
    wr(uefr_pkg::OFF_TRIGGER, 8'h20);
    wr(uefr_pkg::OFF_FEATURE, 8'h30);
    wr(uefr_pkg::OFF_TRIGGER, 8'h10);
    settle();
    chk({tx_trigger, rx_trigger}, 20'h02010);
    rd(uefr_pkg::OFF_FIFO_COUNT, 8'h00, 8'hFF);
    wr(uefr_pkg::OFF_LINE_CONTROL, uefr_pkg::LCR_ENHANCED_KEY);
    rd(uefr_pkg::OFF_FIFO_COUNT, rx_fifo_level, 8'hFF);
    wr(uefr_pkg::OFF_FEATURE, 8'hB0);
    rd(uefr_pkg::OFF_FIFO_COUNT, tx_fifo_level, 8'hFF);
    // infrared polarity, duplex override, transmit interrupt timing
    wr(uefr_pkg::OFF_FEATURE, 8'h04);
    settle();
    chk({ir_rx_invert, half_duplex}, 20'h2);
    pulse(1'b0, 1'b1);
    pulse(1'b1, 1'b0);
    wr(uefr_pkg::OFF_FEATURE, 8'h08);
    settle();
    chk({ir_rx_invert, half_duplex}, 20'h1);
    pulse(1'b0, 1'b0);
    pulse(1'b1, 1'b1);
    d0 = driver_enable;
    rts_internal <= 1'b1;
    settle();
    chk(driver_enable, !d0);
    repeat (2) @(posedge hclk);
    if (q_exp.size() != 0) err("reads left unanswered");
    summarize();
  end
endmodule : test_uefr_regs
